// ===== rtl/dqe_map.svh
// register map, flag codes and descriptor layout for the descriptor queue engine
`ifndef DQE_MAP_SVH
`define DQE_MAP_SVH
// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_LDR_LO 8'h08
`define REG_LDR_HI 8'h0C
`define REG_ENQ0 8'h10
`define REG_ENQ1 8'h14
`define REG_ENQ2 8'h18
`define REG_LAST_DESC 8'h1C
`define REG_DONE_CNT 8'h20
// control and status fields
`define CTRL_ENABLE 0
`define STATUS_OVF_LSB 0
`define STATUS_BUSY 3
// flag word bits
`define FL_CSUM_CLR 13
`define FL_CSUM_ACC 12
`define FL_LITTLE 11
`define FL_TX_ENQ 10
`define FL_HOLD 9
`define FL_EVENT 8
`define FL_NO_STATUS 7
`define FL_DST_AUTO 6
`define FL_IMMED 3
`define FL_SRC_AUTO 2
// masked direction and special codes
`define DIR_MASK 16'h0033
`define FREE_MASK 16'h0013
`define GET_CODE 16'h0031
`define PATCH_SRC_MASK 16'h0070
`define PATCH_SRC_CODE 16'h0050
`define PATCH_DST_CODE 16'h0062
`define POOL_BITS 4
// descriptor chain geometry
`define DESC_STRIDE 32'h0000_0010
`define CHAIN_BITS 6
`define WB_ZERO 32'h0000_0000
`endif

// ===== rtl/dqe_pkg.sv
// types shared by the descriptor queue engine and its neighbours
package dqe_pkg;
    // one descriptor as delivered by the fetch port
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] flags;
        logic [31:0] src;
        logic [31:0] dst;
    } desc_t;
    // command handed to the general transfer mover
    typedef struct packed {
        logic [5:0] dir;
        logic little_end;
        logic csum_clear;
        logic csum_acc;
        logic src_hold;
        logic dst_hold;
        logic immediate;
        logic [31:0] src;
        logic [31:0] dst;
        logic [15:0] count;
    } move_cmd_t;
endpackage

// ===== rtl/dma_descriptor_queue_engine.sv
// descriptor queue engine: three queues feeding the general transfer mover
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "dqe_map.svh"
module dma_descriptor_queue_engine import dqe_pkg::*; #(
    parameter int QDEPTH = 4 // descriptor chains held per queue
) (
    input wire logic clock, // core clock, 40 MHz
    input wire logic reset_n, // asynchronous reset, active low
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [7:0] wb_adr_i, // wishbone byte address
    input wire logic [3:0] wb_sel_i, // wishbone byte lanes
    input wire logic [31:0] wb_dat_i, // wishbone write data
    output logic [31:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o, // wishbone acknowledge
    output logic fetch_req, // descriptor fetch request, held until ack
    output logic [31:0] fetch_addr, // descriptor address
    output logic fetch_local, // descriptor lies in local memory
    input wire logic fetch_ack, // descriptor delivered
    input wire desc_t fetch_data, // fetched descriptor
    output logic move_req, // mover request, held until ack
    output move_cmd_t move_cmd, // mover command
    input wire logic move_ack, // mover finished the transfer
    input wire logic [31:0] move_value, // value moved, for chain patching
    output logic get_req, // buffer get request, held until ack
    output logic [3:0] get_pool, // pool to take a buffer from
    input wire logic get_ack, // buffer granted
    input wire logic [31:0] get_addr, // granted buffer address
    output logic free_req, // one-cycle buffer free pulse
    output logic [31:0] free_addr, // buffer to free
    output logic tx_enq_req, // one-cycle transmit enqueue pulse
    output logic [31:0] tx_enq_addr, // packet address for transmit
    output logic event_req, // one-cycle completion event pulse
    output logic [1:0] event_queue // queue whose descriptor completed
);
    localparam int PW = $clog2(QDEPTH);
    localparam int CW = PW + 1;

    // refuse queue depths the pointer wrap cannot serve
    if (QDEPTH < 2 || (1 << PW) != QDEPTH) begin : g_depth_check
        $error("QDEPTH must be a power of two, at least 2");
    end

    typedef enum logic [2:0] {S_IDLE, S_FETCH, S_GET, S_MOVE, S_POST} state_t;

    ////////////////////////////////////////////////////////////////////////////
    // helper functions

    // merge write data into a register by byte lane
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
        lane_merge = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                lane_merge[8*i +: 8] = new_v[8*i +: 8];
            end
        end
    endfunction

    // end address after a transfer, unless the address is held
    function automatic logic [31:0] addr_end(input logic [31:0] a, input logic [15:0] cnt, input logic hold);
        addr_end = hold ? a : a + {16'h0000, cnt};
    endfunction

    // turn an effective descriptor into a mover command
    function automatic move_cmd_t build_cmd(input desc_t d, input logic [31:0] psrc, input logic [31:0] pdst,
                                            input logic patching);
        move_cmd_t c;
        c = '0;
        c.dir = 6'(d.flags & `DIR_MASK);
        c.little_end = d.flags[`FL_LITTLE];
        c.src_hold = d.flags[`FL_HOLD] && d.flags[`FL_CSUM_ACC];
        c.dst_hold = d.flags[`FL_HOLD] && d.flags[`FL_CSUM_CLR];
        c.csum_acc = d.flags[`FL_CSUM_ACC] && !d.flags[`FL_HOLD];
        c.csum_clear = c.csum_acc && d.flags[`FL_CSUM_CLR];
        c.immediate = d.flags[`FL_IMMED];
        c.src = d.flags[`FL_SRC_AUTO] ? psrc : d.src;
        c.dst = (d.flags[`FL_DST_AUTO] && !patching) ? pdst : d.dst;
        c.count = d.count;
        build_cmd = c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers

    state_t state_r;
    logic wb_ack_r, enable_r, fetch_req_r, fetch_local_r, move_req_r, get_req_r;
    logic free_req_r, tx_enq_req_r, event_req_r, rr_r, patch_src_r, patch_dst_r;
    logic [31:0] wb_dat_r, ldr_lo_r, ldr_hi_r, fetch_addr_r, chain_addr_r, last_desc_r, done_cnt_r;
    logic [31:0] prev_src_r, prev_dst_r, patch_val_r, free_addr_r, tx_enq_addr_r;
    logic [3:0] get_pool_r;
    logic [1:0] cur_q_r, event_queue_r;
    logic [2:0] ovf_r;
    logic [`CHAIN_BITS-1:0] remain_r;
    desc_t desc_r;
    move_cmd_t move_cmd_r;
    logic [31:0] qmem_r [0:2][0:QDEPTH-1];
    logic [PW-1:0] qwp_r [0:2];
    logic [PW-1:0] qrp_r [0:2];
    logic [CW-1:0] qcnt_r [0:2];

    ////////////////////////////////////////////////////////////////////////////
    // wishbone decode; one wait state, ack one cycle after the strobe

    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_r;
    wire bus_wr = bus_req && wb_we_i;
    wire full_word = (wb_sel_i == 4'hF);
    wire wr_ctrl = bus_wr && (wb_adr_i == `REG_CTRL);
    wire wr_status = bus_wr && (wb_adr_i == `REG_STATUS);
    wire wr_ldr_lo = bus_wr && (wb_adr_i == `REG_LDR_LO);
    wire wr_ldr_hi = bus_wr && (wb_adr_i == `REG_LDR_HI);
    // an enqueue needs the whole address, so partial lanes are ignored
    wire [2:0] enq = {3{bus_wr && full_word}} & {wb_adr_i == `REG_ENQ2, wb_adr_i == `REG_ENQ1,
                                                 wb_adr_i == `REG_ENQ0};
    wire [2:0] qfull = {qcnt_r[2] == CW'(QDEPTH), qcnt_r[1] == CW'(QDEPTH), qcnt_r[0] == CW'(QDEPTH)};
    wire [2:0] qready = {qcnt_r[2] != '0, qcnt_r[1] != '0, qcnt_r[0] != '0};
    wire busy = (state_r != S_IDLE);
    wire [31:0] status_v = {21'h000000, qready, 2'b00, cur_q_r, busy, ovf_r};
    wire [31:0] rd_v = (wb_adr_i == `REG_CTRL) ? {31'h0000_0000, enable_r} :
                       (wb_adr_i == `REG_STATUS) ? status_v :
                       (wb_adr_i == `REG_LDR_LO) ? ldr_lo_r :
                       (wb_adr_i == `REG_LDR_HI) ? ldr_hi_r :
                       (wb_adr_i == `REG_LAST_DESC) ? last_desc_r :
                       (wb_adr_i == `REG_DONE_CNT) ? done_cnt_r : `WB_ZERO;

    // register writes; an overflow that arrives with its clear stays set
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_r <= 1'b0;
            wb_dat_r <= `WB_ZERO;
            enable_r <= 1'b0;
            ldr_lo_r <= `WB_ZERO;
            ldr_hi_r <= `WB_ZERO;
            ovf_r <= 3'h0;
        end else begin
            wb_ack_r <= bus_req;
            wb_dat_r <= bus_req ? rd_v : `WB_ZERO;
            if (wr_ctrl && wb_sel_i[0]) begin
                enable_r <= wb_dat_i[`CTRL_ENABLE];
            end
            if (wr_ldr_lo) begin
                ldr_lo_r <= lane_merge(ldr_lo_r, wb_dat_i, wb_sel_i);
            end
            if (wr_ldr_hi) begin
                ldr_hi_r <= lane_merge(ldr_hi_r, wb_dat_i, wb_sel_i);
            end
            ovf_r <= (ovf_r & ~({3{wr_status && wb_sel_i[0]}} & wb_dat_i[2:0])) | (enq & qfull);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // scheduler: queue 0 first, queues 1 and 2 alternate

    wire pick_ok = enable_r && (state_r == S_IDLE) && (qready != 3'h0);
    wire [1:0] pick_q = qready[0] ? 2'd0 :
                        (qready[1] && qready[2]) ? (rr_r ? 2'd2 : 2'd1) :
                        qready[1] ? 2'd1 : 2'd2;
    wire [31:0] pick_addr = qmem_r[pick_q][qrp_r[pick_q]];
    wire [`CHAIN_BITS-1:0] pick_len = pick_addr[`CHAIN_BITS-1:0];
    wire [31:0] pick_base = {pick_addr[31:`CHAIN_BITS], {`CHAIN_BITS{1'b0}}};

    // three queues of chain addresses; an enqueue onto a full queue is dropped
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int q = 0; q < 3; q++) begin
                qwp_r[q] <= '0;
                qrp_r[q] <= '0;
                qcnt_r[q] <= '0;
            end
            rr_r <= 1'b0;
        end else begin
            for (int q = 0; q < 3; q++) begin
                if (enq[q] && !qfull[q]) begin
                    qmem_r[q][qwp_r[q]] <= wb_dat_i;
                    qwp_r[q] <= qwp_r[q] + PW'(1);
                end
                if (pick_ok && pick_q == 2'(q)) begin
                    qrp_r[q] <= qrp_r[q] + PW'(1);
                end
                qcnt_r[q] <= qcnt_r[q] + CW'(enq[q] && !qfull[q]) - CW'(pick_ok && pick_q == 2'(q));
            end
            if (pick_ok && pick_q != 2'd0) begin
                rr_r <= (pick_q == 2'd1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // descriptor decode

    wire [31:0] next_fetch = chain_addr_r + `DESC_STRIDE;
    wire next_local = (next_fetch >= ldr_lo_r) && (next_fetch <= ldr_hi_r);
    wire pick_local = (pick_base >= ldr_lo_r) && (pick_base <= ldr_hi_r);
    // pending patches from the previous descriptor override fetched fields
    wire [15:0] fflags = fetch_data.flags;
    wire patching = patch_src_r || patch_dst_r;
    wire desc_t fetched = '{count: fetch_data.count, flags: fflags,
                            src: patch_src_r ? patch_val_r : fetch_data.src,
                            dst: patch_dst_r ? patch_val_r : fetch_data.dst};
    wire want_get = ((fflags & `GET_CODE) == `GET_CODE);
    wire move_cmd_t cmd_fetch = build_cmd(fetched, prev_src_r, prev_dst_r, patch_dst_r);
    wire desc_t got = '{count: desc_r.count, flags: desc_r.flags, src: desc_r.src, dst: get_addr};
    wire move_cmd_t cmd_got = build_cmd(got, prev_src_r, prev_dst_r, 1'b1);
    wire [15:0] dflags = desc_r.flags;
    wire do_free = ((dflags & `FREE_MASK) == `FREE_MASK);
    wire do_patch_src = ((dflags & `PATCH_SRC_MASK) == `PATCH_SRC_CODE);
    wire do_patch_dst = ((dflags & `PATCH_DST_CODE) == `PATCH_DST_CODE);
    wire post = (state_r == S_POST);

    ////////////////////////////////////////////////////////////////////////////
    // chain walker: fetch, optional buffer get, move, post, next

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= S_IDLE;
            cur_q_r <= 2'd0;
            chain_addr_r <= `WB_ZERO;
            remain_r <= '0;
            fetch_req_r <= 1'b0;
            fetch_addr_r <= `WB_ZERO;
            fetch_local_r <= 1'b0;
            desc_r <= '0;
            get_req_r <= 1'b0;
            get_pool_r <= 4'h0;
            move_req_r <= 1'b0;
            move_cmd_r <= '0;
            prev_src_r <= `WB_ZERO;
            prev_dst_r <= `WB_ZERO;
            patch_src_r <= 1'b0;
            patch_dst_r <= 1'b0;
            patch_val_r <= `WB_ZERO;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (pick_ok) begin
                        cur_q_r <= pick_q;
                        chain_addr_r <= pick_base;
                        remain_r <= (pick_len == '0) ? `CHAIN_BITS'(1) : pick_len;
                        fetch_req_r <= 1'b1;
                        fetch_addr_r <= pick_base;
                        fetch_local_r <= pick_local;
                        state_r <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    if (fetch_ack) begin
                        fetch_req_r <= 1'b0;
                        desc_r <= fetched;
                        patch_src_r <= 1'b0;
                        patch_dst_r <= 1'b0;
                        if (want_get && !patching) begin
                            get_req_r <= 1'b1;
                            get_pool_r <= fetched.dst[`POOL_BITS-1:0];
                            state_r <= S_GET;
                        end else begin
                            move_req_r <= 1'b1;
                            move_cmd_r <= cmd_fetch;
                            state_r <= S_MOVE;
                        end
                    end
                end
                S_GET: begin
                    if (get_ack) begin
                        get_req_r <= 1'b0;
                        desc_r.dst <= get_addr;
                        move_req_r <= 1'b1;
                        move_cmd_r <= cmd_got;
                        state_r <= S_MOVE;
                    end
                end
                S_MOVE: begin
                    if (move_ack) begin
                        move_req_r <= 1'b0;
                        prev_src_r <= addr_end(move_cmd_r.src, move_cmd_r.count, move_cmd_r.src_hold);
                        prev_dst_r <= addr_end(move_cmd_r.dst, move_cmd_r.count, move_cmd_r.dst_hold);
                        patch_src_r <= do_patch_src;
                        patch_dst_r <= do_patch_dst;
                        patch_val_r <= move_value;
                        desc_r.src <= move_cmd_r.src;
                        desc_r.dst <= move_cmd_r.dst;
                        state_r <= S_POST;
                    end
                end
                S_POST: begin
                    // side effects are registered this cycle and go out next cycle, together with the next fetch request
                    chain_addr_r <= next_fetch;
                    remain_r <= remain_r - `CHAIN_BITS'(1);
                    if (remain_r == `CHAIN_BITS'(1)) begin
                        state_r <= S_IDLE;
                    end else begin
                        fetch_req_r <= 1'b1;
                        fetch_addr_r <= next_fetch;
                        fetch_local_r <= next_local;
                        state_r <= S_FETCH;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // completion side effects as one-cycle pulses after the move, and status registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            free_req_r <= 1'b0;
            free_addr_r <= `WB_ZERO;
            tx_enq_req_r <= 1'b0;
            tx_enq_addr_r <= `WB_ZERO;
            event_req_r <= 1'b0;
            event_queue_r <= 2'd0;
            last_desc_r <= `WB_ZERO;
            done_cnt_r <= `WB_ZERO;
        end else begin
            free_req_r <= post && do_free;
            free_addr_r <= desc_r.src;
            tx_enq_req_r <= post && dflags[`FL_TX_ENQ];
            tx_enq_addr_r <= desc_r.dst;
            event_req_r <= post && dflags[`FL_EVENT];
            event_queue_r <= cur_q_r;
            if (post && !dflags[`FL_NO_STATUS]) begin
                last_desc_r <= chain_addr_r;
                done_cnt_r <= done_cnt_r + 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops

    assign wb_ack_o = wb_ack_r;
    assign wb_dat_o = wb_dat_r;
    assign fetch_req = fetch_req_r;
    assign fetch_addr = fetch_addr_r;
    assign fetch_local = fetch_local_r;
    assign move_req = move_req_r;
    assign move_cmd = move_cmd_r;
    assign get_req = get_req_r;
    assign get_pool = get_pool_r;
    assign free_req = free_req_r;
    assign free_addr = free_addr_r;
    assign tx_enq_req = tx_enq_req_r;
    assign tx_enq_addr = tx_enq_addr_r;
    assign event_req = event_req_r;
    assign event_queue = event_queue_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_q0_first: assert property (@(posedge clock) disable iff (!reset_n)
        (pick_ok && qready[0]) |=> (cur_q_r == 2'd0 && state_r == S_FETCH))
        else $error("queue 0 not served first");
    a_rr_turn: assert property (@(posedge clock) disable iff (!reset_n)
        (pick_ok && qready == 3'b110 && rr_r) |=> (cur_q_r == 2'd2))
        else $error("round robin skipped queue 2");
    a_move_held: assert property (@(posedge clock) disable iff (!reset_n)
        (move_req && !move_ack) |=> (move_req && $stable(move_cmd)))
        else $error("mover request dropped or changed");
    a_one_stage: assert property (@(posedge clock) disable iff (!reset_n)
        !(fetch_req && (move_req || get_req)))
        else $error("next descriptor overlaps current one");
    a_fetch_local: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(fetch_req) |-> (fetch_local == ((fetch_addr >= ldr_lo_r) && (fetch_addr <= ldr_hi_r))))
        else $error("local descriptor flag wrong");
    a_status_skip: assert property (@(posedge clock) disable iff (!reset_n)
        (post && dflags[`FL_NO_STATUS]) |=> $stable(done_cnt_r))
        else $error("status recorded though inhibited");
    a_status_count: assert property (@(posedge clock) disable iff (!reset_n)
        (post && !dflags[`FL_NO_STATUS]) |=> (done_cnt_r == $past(done_cnt_r) + 32'h0000_0001))
        else $error("completion not counted");
    a_event_post: assert property (@(posedge clock) disable iff (!reset_n)
        (post && dflags[`FL_EVENT]) |=> (event_req && event_queue == $past(cur_q_r)) ##1 !event_req)
        else $error("completion event missing");
    a_free_src: assert property (@(posedge clock) disable iff (!reset_n)
        (post && do_free) |=> (free_req && free_addr == $past(desc_r.src)))
        else $error("buffer free missing");
    a_get_dst: assert property (@(posedge clock) disable iff (!reset_n)
        (state_r == S_GET && get_ack) |=> (move_req && move_cmd.dst == $past(get_addr)))
        else $error("got buffer not used as destination");
    a_csum_seed: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(move_req) |-> (move_cmd.csum_clear == (dflags[`FL_CSUM_CLR] && dflags[`FL_CSUM_ACC] && !dflags[`FL_HOLD])))
        else $error("checksum cleared without accumulation");
    a_bus_ack: assert property (@(posedge clock) disable iff (!reset_n)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("wishbone ack not one cycle after request");
endmodule // dma_descriptor_queue_engine

// ===== tb/far_side_model.sv
// far side model: descriptor store, transfer mover and buffer pool
`timescale 1ns/1ps
module far_side_model import dqe_pkg::*; (
    input wire logic clock, // core clock
    input wire logic fetch_req, // fetch request
    input wire logic [31:0] fetch_addr, // descriptor address
    input wire logic move_req, // mover request
    input wire logic get_req, // buffer request
    input wire logic [1:0] lag, // answer delay
    output desc_t fetch_data, // descriptor
    output logic fetch_ack, // descriptor delivered
    output logic move_ack, // transfer done
    output logic [31:0] move_value, // moved value
    output logic get_ack, // buffer granted
    output logic [31:0] get_addr // granted buffer
);
    desc_t tab [0:255]; // descriptors placed in local memory by the bench
    int w = 0;
    initial {fetch_data, fetch_ack, move_ack, move_value, get_ack, get_addr} = '0;
    // one answer after lag cycles; idle data toggles so a stale value never passes
    always @(posedge clock) begin
        {fetch_ack, move_ack, get_ack} <= 3'h0;
        {fetch_data, move_value, get_addr} <= ~{fetch_data, move_value, get_addr};
        if ((fetch_req | move_req | get_req) && !(fetch_ack | move_ack | get_ack)) begin
            w <= (w < lag) ? w + 1 : 0;
            if (w >= lag) begin
                {fetch_ack, move_ack, get_ack} <= {fetch_req, move_req, get_req};
                fetch_data <= tab[fetch_addr[11:4]];
                move_value <= 32'h1234_5678;
                get_addr <= 32'h0000_8000;
            end
        end
    end
endmodule // far_side_model

// ===== tb/test_dma_descriptor_queue_engine.sv
// self-checking bench for the descriptor queue engine
`timescale 1ns/1ps
module test_dma_descriptor_queue_engine;
    import dqe_pkg::*;
    logic clock = 0, reset_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF, get_pool;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, fetch_addr, move_value, get_addr, free_addr, tx_enq_addr, q, ps, pd, fa, lst;
    logic wb_ack_o, fetch_req, fetch_local, fetch_ack, move_req, move_ack, get_req, get_ack, free_req, tx_enq_req;
    logic event_req;
    logic [1:0] event_queue, lag = 2'h0;
    desc_t fetch_data;
    move_cmd_t move_cmd, mc, em;
    int n_fail = 0, tests_run = 0, done = 0, seed = 32'hF3D1, n0;
    logic [1:0] pt = 2'h0;
    int order [8] = '{0, 0, 0, 0, 0, 1, 1, 2};
    logic [31:0] ev_q [$], fr_q [$], tx_q [$];
    logic [15:0] codes [24] = '{16'h3000, 16'h1000, 16'h0800, 16'h0400, 16'h0100, 16'h0080, 16'h0050, 16'h0001,
        16'h0062, 16'h0010, 16'h0012, 16'h0013, 16'h0017, 16'h0002, 16'h0020, 16'h0021, 16'h0031, 16'h0008,
        16'h0004, 16'h000C, 16'h0040, 16'h2200, 16'h1200, 16'h0D53};
    dma_descriptor_queue_engine #(.QDEPTH(4)) i_dma_descriptor_queue_engine (.clock, .reset_n, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .fetch_req, .fetch_addr, .fetch_local,
        .fetch_ack, .fetch_data, .move_req, .move_cmd, .move_ack, .move_value, .get_req, .get_pool, .get_ack,
        .get_addr, .free_req, .free_addr, .tx_enq_req, .tx_enq_addr, .event_req, .event_queue);
    far_side_model i_far_side_model (.clock, .fetch_req, .fetch_addr, .move_req, .get_req, .lag, .fetch_data,
        .fetch_ack, .move_ack, .move_value, .get_ack, .get_addr);
    always #12.5 clock = ~clock;
    task automatic chk(input string nm, input logic [95:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // classic wishbone cycle, held until ack; read data kept in q
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
        do @(posedge clock); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // record pulses and handshakes at the edge that carries them
    always @(posedge clock) begin
        if (event_req === 1'b1) ev_q.push_back(32'(event_queue));
        if (free_req === 1'b1) fr_q.push_back(free_addr);
        if (tx_enq_req === 1'b1) tx_q.push_back(tx_enq_addr);
        if (get_req === 1'b1 && get_ack === 1'b1) chk("pool", get_pool, 4'h3);
        if (fetch_req === 1'b1 && fetch_ack === 1'b1) chk("fetch", {fetch_local, fetch_addr}, {1'b1, fa});
        if (move_req === 1'b1 && move_ack === 1'b1) begin
            mc = move_cmd;
            done++;
        end
    end
    initial begin
        #1000000;
        n_fail++;
        wrap_up;
    end
    initial begin
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        wb(1'b1, 8'h0C, 32'h0000_0FFF);
        wb(1'b1, 8'h00, 32'h0000_0001);
        wb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped", q, 32'h0);
        // each flag code and one ORed mix; descriptor queueing only
        foreach (codes[i]) begin
            logic [15:0] f, c;
            f = codes[i];
            c = 16'($unsigned($random(seed)) % 200 + 1);
            lag <= 2'($random(seed));
            fa = 32'(i * 64);
            i_far_side_model.tab[i * 4] = {c, f, 32'h0000_1000 + 32'(i), 32'h0000_2003};
            em = '{f[5:0] & 6'h33, f[11], f[13] & f[12] & !f[9], f[12] & !f[9], f[9] & f[12], f[9] & f[13], f[3],
                f[2] ? ps : pt[0] ? 32'h1234_5678 : 32'h0000_1000 + 32'(i),
                (f & 16'h0031) == 16'h0031 ? 32'h0000_8000 : f[6] ? pd : pt[1] ? 32'h1234_5678 : 32'h2003, c};
            n0 = done;
            wb(1'b1, 8'h10 + 8'(4 * (i % 3)), fa + 32'h1);
            // the watchdog ends a move that never completes
            while (done == n0) @(posedge clock);
            repeat (4) @(posedge clock);
            chk("move_cmd", mc, em);
            chk("free", fr_q.size() ? fr_q.pop_front() : 32'hF, (f & 16'h0013) == 16'h0013 ? em.src : 32'hF);
            chk("tx", tx_q.size() ? tx_q.pop_front() : 32'hF, f[10] ? em.dst : 32'hF);
            chk("event", ev_q.size() ? ev_q.pop_front() : 32'hF, f[8] ? 32'(i % 3) : 32'hF);
            if (!f[7]) lst = fa;
            wb(1'b0, 8'h1C, 32'h0);
            chk("last_desc", q, lst);
            ps = em.src_hold ? em.src : em.src + 32'(c);
            pd = em.dst_hold ? em.dst : em.dst + 32'(c);
            // 0050 patches the next source, 0062 the next destination, with the moved value
            pt = {(f & 16'h0062) == 16'h0062, (f & 16'h0070) == 16'h0050};
            $display("code %h done", f);
        end
        // queue 0 first, then 1 and 2 alternate; a fifth chain on full queue 0 is dropped
        wb(1'b1, 8'h00, 32'h0);
        fa = 32'h0000_0640;
        i_far_side_model.tab[100] = {16'h0004, 16'h0100, 32'h0, 32'h0};
        foreach (order[k]) wb(1'b1, 8'h10 + 8'(4 * order[k]), 32'h0000_0641);
        wb(1'b0, 8'h04, 32'h0);
        chk("status", {q[10:8], q[2:0]}, 6'h39);
        wb(1'b1, 8'h00, 32'h0000_0001);
        while (ev_q.size() < 7) @(posedge clock);
        chk("order", {ev_q[0][1:0], ev_q[3][1:0], ev_q[4][1:0] ^ ev_q[5][1:0], ev_q[6][1:0]}, 8'h0D);
        $display("queue order done");
        wrap_up;
    end
endmodule // test_dma_descriptor_queue_engine
